/* logic/oscctl_top.sv */
/*
  Oscillator control registers: internal oscillator control and calibration, external oscillator control.
  Assumes a synchronous special function bus from the core and a stable flag from the external detector.
*/
`timescale 1ns/1ps
`include "oscctl_defines.svh"

// Behaviour
// - Internal control bit 7 turns the internal oscillator on when one, and it resets to zero.
// - Internal control bit 6 reads one only while the internal oscillator runs at its programmed frequency.
// - Calibration bit 7 switches spread-spectrum dithering on when one, and it resets to zero.
// - A larger seven-bit trim code lowers the internal frequency, a smaller one raises it.
// - Each trim step moves the internal frequency by about one percent.
// - The trim code loads the factory value one edge after reset release, giving the nominal internal frequency.
// - The external valid flag reads zero in either CMOS clock mode, except for one cycle after that mode is written.
// - In other modes the external valid flag is one only while the external oscillator runs stable.
// - Mode codes 00x disable the external circuit, 010 picks CMOS input and 011 CMOS input halved.
// - Mode code 100 picks RC, 101 capacitor and 110 crystal operation.
// - Mode code 111 picks crystal halved, and the mode field resets to zero.
// - External control bit 3 reads zero and software writes it zero.
// - The three-bit bias field in bits 2 to 0 takes all eight codes and resets to zero.
module oscctl_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Special function bus.
  input wire oscctl_pkg::oscctl_bus_s bus,
  output logic [7:0] rdData,
  // External oscillator detector and factory trim strap.
  input wire logic extStable,
  input wire logic [6:0] factoryTrim,
  // Oscillator controls.
  output oscctl_pkg::oscctl_ana_s ana
);

  typedef struct packed {
    logic intOscOn;
    logic [5:0] intRsvd;
    logic ditherEnable;
    logic [6:0] intTrimCode;
    logic [2:0] extOscModeSel;
    logic [2:0] extBiasLevel;
    logic extOscValid;
    logic trimLoaded;
    logic [7:0] rdData;
    oscctl_pkg::oscctl_ana_s ana;
  } oscctl_regs_s;

  oscctl_regs_s regs_r;
  oscctl_regs_s regs_nxt;
  logic intFreqReady;

  // Modes in which the valid flag ignores the external detector.
  function automatic logic isCmos(input logic [2:0] m);
    isCmos = (m == `OSC_MODE_CMOS) || (m == `OSC_MODE_CMOS_DIV2);
  endfunction

  // Modes in which the external circuit is off.
  function automatic logic isOff(input logic [2:0] m);
    isOff = (m == `OSC_MODE_OFF0) || (m == `OSC_MODE_OFF1);
  endfunction

  // ************************************************
  // Internal oscillator readiness
  // ************************************************
  // Fed from the next register values: readiness then falls on the same edge that
  // disables or retrims the oscillator, so a read never sees a stale ready bit.
  oscctl_int_watch uWatch (
    .clk(clk),
    .rst(rst),
    .enable(regs_nxt.intOscOn),
    .trimCode(regs_nxt.intTrimCode),
    .ready(intFreqReady)
  );

  // ************************************************
  // Register file
  // ************************************************
  // Writes, read mux and oscillator settings; every output is registered.
  always_comb begin
    regs_nxt = regs_r;
    // The factory trim is a strap, so it is caught one edge after reset release.
    if (!regs_r.trimLoaded) begin
      regs_nxt.intTrimCode = factoryTrim;
      regs_nxt.trimLoaded = 1'b1;
    end
    if (bus.wrEn) begin
      case (bus.addr)
        `OSC_ADDR_INT_CTRL: begin
          regs_nxt.intOscOn = bus.wrData[`OSC_INT_ON_BIT];
          regs_nxt.intRsvd = bus.wrData[5:0];
        end
        `OSC_ADDR_INT_CAL: begin
          regs_nxt.ditherEnable = bus.wrData[`OSC_DITHER_BIT];
          regs_nxt.intTrimCode = bus.wrData[6:0];
          regs_nxt.trimLoaded = 1'b1;
        end
        `OSC_ADDR_EXT_CTRL: begin
          regs_nxt.extOscModeSel = bus.wrData[6:4];
          regs_nxt.extBiasLevel = bus.wrData[2:0];
        end
        default: begin
        end
      endcase
    end
    // Valid only when a non-CMOS circuit runs and the detector agrees.
    regs_nxt.extOscValid = extStable && !isCmos(regs_r.extOscModeSel) && !isOff(regs_r.extOscModeSel);
    case (bus.addr)
      `OSC_ADDR_INT_CTRL: regs_nxt.rdData = {regs_r.intOscOn, intFreqReady, regs_r.intRsvd};
      `OSC_ADDR_INT_CAL: regs_nxt.rdData = {regs_r.ditherEnable, regs_r.intTrimCode};
      `OSC_ADDR_EXT_CTRL: regs_nxt.rdData = {regs_r.extOscValid, regs_r.extOscModeSel, 1'b0,
        regs_r.extBiasLevel};
      default: regs_nxt.rdData = 8'h00;
    endcase
    if (!bus.rdEn) begin
      regs_nxt.rdData = 8'h00;
    end
    // Analog settings follow the committed registers; a trim step is about one percent.
    regs_nxt.ana.intOscOn = regs_nxt.intOscOn;
    regs_nxt.ana.ditherEnable = regs_nxt.ditherEnable;
    regs_nxt.ana.intTrimCode = regs_nxt.intTrimCode;
    regs_nxt.ana.extOscModeSel = isOff(regs_nxt.extOscModeSel) ? `OSC_MODE_OFF0 : regs_nxt.extOscModeSel;
    regs_nxt.ana.extBiasLevel = regs_nxt.extBiasLevel;
    regs_nxt.ana.extDivide2 = (regs_nxt.extOscModeSel == `OSC_MODE_CMOS_DIV2) ||
      (regs_nxt.extOscModeSel == `OSC_MODE_XTAL_DIV2);
  end

  // Single state register; reset values are constants only.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regs_r <= '0;
      regs_r.intTrimCode <= `OSC_TRIM_DEFAULT;
      regs_r.ana.intTrimCode <= `OSC_TRIM_DEFAULT;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  assign rdData = regs_r.rdData;
  assign ana = regs_r.ana;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_enWrite;
    bus.wrEn && bus.addr == `OSC_ADDR_INT_CTRL |=> ana.intOscOn == $past(bus.wrData[7]);
  endproperty
  a_enWrite: assert property (p_enWrite) else $error("Enable not taken from write.");

  property p_rdyOff;
    !regs_r.intOscOn |-> !intFreqReady;
  endproperty
  a_rdyOff: assert property (p_rdyOff) else $error("Ready while disabled.");

  property p_dither;
    bus.wrEn && bus.addr == `OSC_ADDR_INT_CAL |=> ana.ditherEnable == $past(bus.wrData[7]);
  endproperty
  a_dither: assert property (p_dither) else $error("Dither not taken.");

  property p_trim;
    bus.wrEn && bus.addr == `OSC_ADDR_INT_CAL |=> ana.intTrimCode == $past(bus.wrData[6:0]);
  endproperty
  a_trim: assert property (p_trim) else $error("Trim not taken.");

  property p_cmosInvalid;
    isCmos(regs_r.extOscModeSel) |=> !regs_r.extOscValid;
  endproperty
  a_cmosInvalid: assert property (p_cmosInvalid) else $error("Valid in CMOS mode.");

  property p_validTrack;
    !isCmos(regs_r.extOscModeSel) && !isOff(regs_r.extOscModeSel) && !bus.wrEn |=>
      regs_r.extOscValid == $past(extStable);
  endproperty
  a_validTrack: assert property (p_validTrack) else $error("Valid does not follow detector.");

  property p_offMode;
    isOff(regs_r.extOscModeSel) |-> ##1 ana.extOscModeSel == `OSC_MODE_OFF0 || $past(bus.wrEn);
  endproperty
  a_offMode: assert property (p_offMode) else $error("External circuit not off.");

  property p_div2;
    ana.extDivide2 |-> ana.extOscModeSel[0] && ana.extOscModeSel[1];
  endproperty
  a_div2: assert property (p_div2) else $error("Divide stage in wrong mode.");

  property p_rsvdZero;
    bus.rdEn && bus.addr == `OSC_ADDR_EXT_CTRL |=> !rdData[`OSC_EXT_RSVD_BIT];
  endproperty
  a_rsvdZero: assert property (p_rsvdZero) else $error("Reserved bit read one.");

  property p_bias;
    bus.wrEn && bus.addr == `OSC_ADDR_EXT_CTRL |=> ana.extBiasLevel == $past(bus.wrData[2:0]);
  endproperty
  a_bias: assert property (p_bias) else $error("Bias not taken.");

  c_ready: cover property (regs_r.intOscOn ##[1:20] intFreqReady);
  c_xtalValid: cover property (regs_r.extOscModeSel == `OSC_MODE_XTAL && regs_r.extOscValid);
  c_rcValid: cover property (regs_r.extOscModeSel == `OSC_MODE_RC ##1 regs_r.extOscValid);

endmodule

/* logic/oscctl_defines.svh */
/*
  Register addresses, field positions, mode codes and timing counts for the oscillator control block.
  Assumes it is included by bare name into the package and the design modules.
*/
`ifndef OSCCTL_DEFINES_SVH
`define OSCCTL_DEFINES_SVH

// ************************************************
// Register addresses on the special function bus
// ************************************************
`define OSC_ADDR_EXT_CTRL 8'hB1
`define OSC_ADDR_INT_CTRL 8'hB2
`define OSC_ADDR_INT_CAL 8'hB3

// ************************************************
// Field positions
// ************************************************
`define OSC_INT_ON_BIT 7
`define OSC_INT_RDY_BIT 6
`define OSC_DITHER_BIT 7
`define OSC_EXT_VALID_BIT 7
`define OSC_EXT_RSVD_BIT 3

// ************************************************
// Reset values
// ************************************************
`define OSC_EXT_CTRL_RST 8'h00
`define OSC_INT_RSVD_RST 6'h00
`define OSC_TRIM_DEFAULT 7'h40

// ************************************************
// External mode codes
// ************************************************
`define OSC_MODE_OFF0 3'h0
`define OSC_MODE_OFF1 3'h1
`define OSC_MODE_CMOS 3'h2
`define OSC_MODE_CMOS_DIV2 3'h3
`define OSC_MODE_RC 3'h4
`define OSC_MODE_CAP 3'h5
`define OSC_MODE_XTAL 3'h6
`define OSC_MODE_XTAL_DIV2 3'h7

// ************************************************
// Timing: settle time in ns at 20 ns per clock
// ************************************************
`define OSC_CLK_NS 20
`define OSC_INT_SETTLE_NS 200
`define OSC_INT_SETTLE_CYC (`OSC_INT_SETTLE_NS / `OSC_CLK_NS)
`define OSC_CNT_W 4
`define OSC_CNT_ZERO 4'h0
`define OSC_CNT_ONE 4'h1

`endif

/* logic/oscctl_pkg.sv */
/*
  Types shared by the oscillator control block.
  Assumes oscctl_defines.svh is on the include path.
*/
`include "oscctl_defines.svh"

package oscctl_pkg;

  // Bus access from the core, one register per address.
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } oscctl_bus_s;

  // Settings driven to the analog oscillators.
  typedef struct packed {
    logic intOscOn;
    logic ditherEnable;
    logic [6:0] intTrimCode;
    logic [2:0] extOscModeSel;
    logic [2:0] extBiasLevel;
    logic extDivide2;
  } oscctl_ana_s;

  typedef enum logic [1:0] {
    OSC_OFF,
    OSC_SETTLE,
    OSC_READY
  } oscctl_int_e;

  // Watcher state: phase, settle counter, ready flag and the trim code last seen.
  typedef struct packed {
    oscctl_int_e phase;
    logic [`OSC_CNT_W-1:0] cnt;
    logic ready;
    logic [6:0] trimSeen;
  } oscctl_watch_s;

endpackage

/* logic/oscctl_int_watch.sv */
/*
  Tracks whether the internal oscillator runs at its programmed frequency.
  Assumes enable and trim are the next values of registers in the same clock domain,
  so a change is seen on the very edge that commits it.
*/
`timescale 1ns/1ps
`include "oscctl_defines.svh"

module oscctl_int_watch (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Settings.
  input wire logic enable,
  input wire logic [6:0] trimCode,
  // Status.
  output logic ready
);

  oscctl_pkg::oscctl_watch_s state_r;
  oscctl_pkg::oscctl_watch_s state_nxt;

  // A trim change in the ready phase re-tunes the oscillator, so readiness is lost until it settles again.
  always_comb begin
    state_nxt = state_r;
    case (state_r.phase)
      oscctl_pkg::OSC_OFF: begin
        if (enable) begin
          state_nxt.phase = oscctl_pkg::OSC_SETTLE;
          state_nxt.cnt = `OSC_CNT_W'(`OSC_INT_SETTLE_CYC);
        end
      end
      oscctl_pkg::OSC_SETTLE: begin
        if (state_r.cnt == `OSC_CNT_ONE) begin
          state_nxt.phase = oscctl_pkg::OSC_READY;
        end
        state_nxt.cnt = state_r.cnt - `OSC_CNT_ONE;
      end
      oscctl_pkg::OSC_READY: begin
        if (trimCode != state_r.trimSeen) begin
          state_nxt.phase = oscctl_pkg::OSC_SETTLE;
          state_nxt.cnt = `OSC_CNT_W'(`OSC_INT_SETTLE_CYC);
        end
      end
      default: begin
        state_nxt.phase = oscctl_pkg::OSC_OFF;
      end
    endcase
    if (!enable) begin
      state_nxt.phase = oscctl_pkg::OSC_OFF;
      state_nxt.cnt = `OSC_CNT_ZERO;
    end
    state_nxt.ready = (state_nxt.phase == oscctl_pkg::OSC_READY) && (trimCode == state_r.trimSeen);
    state_nxt.trimSeen = trimCode;
  end

  // Single state register, trim copy included; reset values are constants only.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= '{phase: oscctl_pkg::OSC_OFF, cnt: `OSC_CNT_ZERO, ready: 1'b0, trimSeen: `OSC_TRIM_DEFAULT};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign ready = state_r.ready;

endmodule

/* bench/oscctl_ext_osc.sv */
/*
  Behavioural external oscillator with its stable detector, plus the factory trim strap.
  Assumes the mode comes from the block's analog outputs and shares the bench clock.
*/
`timescale 1ns/1ps

// ************************************************
// External source model
// ************************************************
module oscctl_ext_osc #(
  parameter int START = 8,
  parameter logic [6:0] TRIM = 7'h5A
) (
  // Clock and mode.
  input wire logic clk,
  input wire logic [2:0] mode,
  // Detector level and strap.
  output logic extStable,
  output logic [6:0] factoryTrim
);
  logic [2:0] lastMode = 3'h0;
  int cnt = 0;

  // A resonant source restarts on any mode change, so the detector never reports an old oscillator.
  always @(posedge clk) begin
    if (mode != lastMode) cnt <= 0;
    else if (cnt < START) cnt <= cnt + 1;
    lastMode <= mode;
  end

  // A CMOS clock is on the pin at once, which tempts a design to report it; off modes show nothing.
  assign extStable = mode[2] ? (mode == lastMode && cnt >= START) : mode[1];
  assign factoryTrim = TRIM;
endmodule

/* bench/oscctl_test.sv */
/*
  Self-checking bench for the oscillator control registers.
  Assumes the external oscillator model drives the detector and strap inputs.
*/
`timescale 1ns/1ps
`include "oscctl_defines.svh"

// ************************************************
// Bench top
// ************************************************
module oscctl_test;
  localparam logic [6:0] TRIM = 7'h5A;
  logic clk = 1'b0;
  logic rst = 1'b1;
  oscctl_pkg::oscctl_bus_s bus = '0;
  logic [7:0] rdData;
  logic extStable;
  logic [6:0] factoryTrim;
  oscctl_pkg::oscctl_ana_s ana;
  int error_cnt = 0;
  int cmp_count = 0;

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  oscctl_top dut_u (.clk(clk), .rst(rst), .bus(bus), .rdData(rdData), .extStable(extStable),
    .factoryTrim(factoryTrim), .ana(ana));
  oscctl_ext_osc #(.START(8), .TRIM(TRIM)) osc_u (.clk(clk), .mode(ana.extOscModeSel),
    .extStable(extStable), .factoryTrim(factoryTrim));

  // Compare and count.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe; the write lands on the second edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask

  // Read data is registered, so it is sampled just after the taking edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    bus <= '0;
    #1 d = rdData;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  // Reset for 8 cycles, then check the reset values, with the factory trim in place of the trim default.
  task automatic t_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1 chk({7'h0, ana.intOscOn}, 8'h00);
    rchk(`OSC_ADDR_EXT_CTRL, 8'h00);
    rchk(`OSC_ADDR_INT_CTRL, 8'h00);
    rchk(`OSC_ADDR_INT_CAL, {1'b0, TRIM});
    chk({1'b0, ana.intTrimCode}, {1'b0, TRIM});
  endtask

  // Enable by read-modify-write, wait for ready, retrim, then disable.
  task automatic t_int;
    logic [7:0] v;
    wr(`OSC_ADDR_INT_CTRL, 8'h15);
    rd(`OSC_ADDR_INT_CTRL, v);
    wr(`OSC_ADDR_INT_CTRL, v | 8'h80);
    chk({7'h0, ana.intOscOn}, 8'h01);
    rchk(`OSC_ADDR_INT_CTRL, 8'h95);
    repeat (14) @(posedge clk);
    rchk(`OSC_ADDR_INT_CTRL, 8'hD5);
    wr(`OSC_ADDR_INT_CAL, {1'b1, TRIM + 7'h10});
    chk({7'h0, ana.ditherEnable}, 8'h01);
    chk({1'b0, ana.intTrimCode}, {1'b0, TRIM + 7'h10});
    rchk(`OSC_ADDR_INT_CTRL, 8'h95);
    rchk(`OSC_ADDR_INT_CAL, {1'b1, TRIM + 7'h10});
    repeat (14) @(posedge clk);
    rd(`OSC_ADDR_INT_CTRL, v);
    chk(v, 8'hD5);
    wr(`OSC_ADDR_INT_CTRL, v & 8'h7F);
    wr(`OSC_ADDR_INT_CAL, {1'b0, TRIM});
    chk({7'h0, ana.ditherEnable}, 8'h00);
    rchk(`OSC_ADDR_INT_CTRL, 8'h15);
  endtask

  // Every mode code with a matching bias; the written valid bit must be ignored.
  task automatic t_ext;
    logic [7:0] v;
    logic [7:0] msk;
    for (int m = 0; m < 8; m++) begin
      msk = (m == 1) ? 8'hEF : 8'hFF;
      wr(`OSC_ADDR_EXT_CTRL, {1'b1, m[2:0], 1'b0, m[2:0]});
      chk({5'h0, ana.extOscModeSel}, (m == 1) ? 8'h00 : 8'(m));
      chk({7'h0, ana.extDivide2}, {7'h0, m == 3 || m == 7});
      chk({5'h0, ana.extBiasLevel}, 8'(m));
      rd(`OSC_ADDR_EXT_CTRL, v);
      chk(v & msk, {1'b0, m[2:0], 1'b0, m[2:0]} & msk);
      // Give the source time to settle before trusting it.
      repeat (12) @(posedge clk);
      rd(`OSC_ADDR_EXT_CTRL, v);
      chk(v & msk, {m[2], m[2:0], 1'b0, m[2:0]} & msk);
    end
  endtask

  // Reserved bit, unmapped addresses and their lack of side effects.
  task automatic t_refuse;
    wr(`OSC_ADDR_EXT_CTRL, 8'h0F);
    rchk(`OSC_ADDR_EXT_CTRL, 8'h07);
    wr(8'hB4, 8'hFF);
    wr(8'hB0, 8'hFF);
    rchk(8'hB4, 8'h00);
    rchk(8'hB0, 8'h00);
    rchk(`OSC_ADDR_EXT_CTRL, 8'h07);
  endtask

  // Print counts and the verdict, then stop.
  task automatic close_out;
    $display("TB: errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence, ending with a reset in mid-run.
  initial begin
    t_reset();
    t_int();
    t_ext();
    t_refuse();
    t_reset();
    close_out();
  end

  // The whole run needs well under a thousand cycles, so a hang is cut off early.
  initial begin
    #50000;
    error_cnt++;
    close_out();
  end
endmodule
